// *** shared/wrf_regs.svh ***
// register offsets, field positions, reset values and timing figures
// assumes the serial-bus engine presents one byte command per write
`ifndef WRF_REGS_SVH
`define WRF_REGS_SVH

// ----------------------------------------
// byte offsets
// ----------------------------------------
`define WRF_OFF_TIMER 8'h04
`define WRF_OFF_WDCTL 8'h09
`define WRF_OFF_SKEW 8'h0A
`define WRF_OFF_RECN 8'h0B
`define WRF_OFF_RECM 8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define WRF_TMR_STEP_BIT 0
`define WRF_TMR_VAL_LSB 1
`define WRF_TMR_VAL_MSB 5
`define WRF_WATCHDOG_ENABLE_BIT 1
`define WRF_WD_FLAG_BIT 2
`define WRF_WD_KEEP_LSB 3
`define WRF_WD_KEEP_MSB 6
`define WRF_WD_RSTEN_BIT 4
`define WRF_SK_AGP_LSB 0
`define WRF_SK_AGP_MSB 1
`define WRF_SK_CPU_LSB 2
`define WRF_SK_CPU_MSB 4
`define WRF_SK_CS_LSB 5
`define WRF_SK_CS_MSB 7
`define WRF_RM_SEL_BIT 7
`define WRF_RM_M_MSB 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define WRF_RST_TMR_VAL 5'h1F
`define WRF_RST_STEP 1'b0
`define WRF_RST_ZERO8 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define WRF_CLK_PERIOD_NS 100.0
`define WRF_STEP_SHORT_MS 150
`define WRF_STEP_LONG_S 2.5
`define WRF_RST_PULSE_NS 1000
`define WRF_STRAP_SETTLE 2'h3

// ----------------------------------------
// skew steps in ps
// ----------------------------------------
`define WRF_PS_0 11'sh000
`define WRF_PS_P150 11'sh096
`define WRF_PS_P300 11'sh12C
`define WRF_PS_P450 11'sh1C2
`define WRF_PS_P600 11'sh258
`endif

// *** shared/wrf_pkg.sv ***
// types shared by the watchdog recovery control
// assumes nothing of its surroundings
package wrf_pkg;
    // gray codes along idle, armed, counting, locked
    typedef enum logic [1:0] {
        WRF_IDLE = 2'h0,
        WRF_ARMED = 2'h1,
        WRF_COUNT = 2'h3,
        WRF_LOCKED = 2'h2
    } wrf_state_e;
    typedef logic signed [10:0] wrf_ps_t;
endpackage

// *** rtl/wrf_step_tick.sv ***
// step tick generator for the watchdog count
// assumes restart_i is held while the watchdog is not counting
`timescale 1ns/10ps
module wrf_step_tick #(
    parameter int SHORT_CYC = 1500000,
    parameter int LONG_CYC = 25000000
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // control
    input wire logic restart_i,
    input wire logic long_step_i,
    // tick
    output logic tick_o
);
    logic [24:0] cnt_r;
    logic [24:0] last_w;

    assign last_w = long_step_i ? 25'(LONG_CYC - 1) : 25'(SHORT_CYC - 1);
    // restart keeps the first step a full step long
    assign tick_o = !restart_i && (cnt_r >= last_w);

    always_ff @(posedge clock_i) begin
        if (!rst_b_i || restart_i || tick_o) begin
            cnt_r <= 25'h0000000;
        end else begin
            cnt_r <= cnt_r + 25'h0000001;
        end
    end
endmodule

// *** rtl/wrf_watchdog_top.sv ***
// watchdog, recovery frequency lock, recovery source and skew control
// assumes a byte-wide command port from the serial-bus engine, one clock
`timescale 1ns/10ps
`include "wrf_regs.svh"

// How it works
// - time-out flag reads 1 after a time-out; writing 1 clears, 0 ignored.
// - enable low keeps counter stopped and reloaded with the time-out value.
// - enabled watchdog starts counting only after an output frequency change.
// - time-out issues reset if reset enabled, loads recovery frequency, enters locked recovery mode.
// - in recovery mode every frequency-change write is ignored.
// - clearing the enable leaves recovery mode and releases the lock.
// - source select 0 uses latched straps, 1 uses programmed recovery dividers.
// - programmed recovery uses 8-bit N and 7-bit M divider fields.
// - ratio follows latched straps unless override set, then software select.
// - chipset cpu skew 3-bit code maps to none, -150..-450, +150..+600 ps.
// - main cpu pair skew uses the same eight-step code.
// - agp_clock_skew 2-bit code maps none, -150, +150, +300 ps.
// - watchdog control, skew and recovery bytes reset to zero.
// - time-out value counts in 150 ms or 2.5 s steps by step select.
// - count reaching zero sets the time-out flag.
// - reset pulse on time-out only when watchdog reset enable is 1.
module wrf_watchdog_top import wrf_pkg::*; #(
    parameter int STEP_SHORT_CYC = int'(`WRF_STEP_SHORT_MS * 1.0e6 / `WRF_CLK_PERIOD_NS),
    parameter int STEP_LONG_CYC = int'(`WRF_STEP_LONG_S * 1.0e9 / `WRF_CLK_PERIOD_NS)
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // register command port
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // frequency path
    input wire logic freq_change_i,
    input wire logic freq_wr_req_i,
    output logic freq_wr_allow_o,
    // strap pins and ratio select
    input wire logic [4:0] strap_frequency_select_i,
    input wire logic ratio_override_i,
    input wire logic [4:0] sw_ratio_sel_i,
    output logic [4:0] ratio_sel_o,
    // recovery
    output logic sys_reset_o,
    output logic recovery_load_o,
    output logic recovery_active_o,
    output logic recovery_source_select_o,
    output logic [7:0] recovery_n_divider_o,
    output logic [6:0] recovery_m_divider_o,
    output logic [4:0] recovery_strap_o,
    // skew
    output wrf_ps_t cpu_cs_skew_ps_o,
    output wrf_ps_t cpu_skew_ps_o,
    output wrf_ps_t agp_clock_skew_ps_o
);
    localparam int RST_CYC_I = int'(`WRF_RST_PULSE_NS / `WRF_CLK_PERIOD_NS);
    localparam logic [3:0] RST_CYC = 4'(RST_CYC_I);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [4:0] timeout_value_r;
    logic timeout_step_select_r;
    logic watchdog_enable_r;
    logic timeout_flag_r;
    logic watchdog_reset_enable_r;
    logic [3:0] wd_keep_r;
    logic [7:0] skew_r;
    logic [7:0] recovery_n_r;
    logic [7:0] recovery_sel_m_r;
    logic wr_timer_w, wr_ctl_w, wr_skew_w, wr_n_w, wr_m_w;

    assign wr_timer_w = reg_wr_i && (reg_addr_i == `WRF_OFF_TIMER);
    assign wr_ctl_w = reg_wr_i && (reg_addr_i == `WRF_OFF_WDCTL);
    assign wr_skew_w = reg_wr_i && (reg_addr_i == `WRF_OFF_SKEW);
    assign wr_n_w = reg_wr_i && (reg_addr_i == `WRF_OFF_RECN);
    assign wr_m_w = reg_wr_i && (reg_addr_i == `WRF_OFF_RECM);
    assign watchdog_reset_enable_r = wd_keep_r[`WRF_WD_RSTEN_BIT - `WRF_WD_KEEP_LSB];

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            timeout_value_r <= `WRF_RST_TMR_VAL;
            timeout_step_select_r <= `WRF_RST_STEP;
        end else if (wr_timer_w) begin
            timeout_value_r <= reg_wdata_i[`WRF_TMR_VAL_MSB:`WRF_TMR_VAL_LSB];
            timeout_step_select_r <= reg_wdata_i[`WRF_TMR_STEP_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            watchdog_enable_r <= 1'b0;
            wd_keep_r <= 4'h0;
            skew_r <= `WRF_RST_ZERO8;
            recovery_n_r <= `WRF_RST_ZERO8;
            recovery_sel_m_r <= `WRF_RST_ZERO8;
        end else begin
            if (wr_ctl_w) begin
                watchdog_enable_r <= reg_wdata_i[`WRF_WATCHDOG_ENABLE_BIT];
                wd_keep_r <= reg_wdata_i[`WRF_WD_KEEP_MSB:`WRF_WD_KEEP_LSB];
            end
            if (wr_skew_w) begin
                skew_r <= reg_wdata_i;
            end
            if (wr_n_w) begin
                recovery_n_r <= reg_wdata_i;
            end
            if (wr_m_w) begin
                recovery_sel_m_r <= reg_wdata_i;
            end
        end
    end

    // ----------------------------------------
    // strap latch
    // ----------------------------------------
    logic [4:0] strap_s1_r, strap_s2_r, strap_s3_r, strap_latched_r;
    logic [1:0] settle_r;
    logic latched_r;

    always_ff @(posedge clock_i) begin
        strap_s1_r <= strap_frequency_select_i;
        strap_s2_r <= strap_s1_r;
        strap_s3_r <= strap_s2_r;
    end

    // caught after release, never by the reset itself
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            settle_r <= 2'h0;
            latched_r <= 1'b0;
            strap_latched_r <= 5'h00;
        end else if (!latched_r) begin
            if (settle_r != `WRF_STRAP_SETTLE) begin
                settle_r <= settle_r + 2'h1;
            end else if (strap_s2_r == strap_s3_r) begin
                strap_latched_r <= strap_s3_r;
                latched_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // watchdog state and count
    // ----------------------------------------
    wrf_state_e state_r;
    logic [4:0] count_r;
    logic step_tick_w;
    logic expire_w;

    wrf_step_tick #(
        .SHORT_CYC(STEP_SHORT_CYC),
        .LONG_CYC(STEP_LONG_CYC)
    ) u_tick (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .restart_i(state_r != WRF_COUNT),
        .long_step_i(timeout_step_select_r),
        .tick_o(step_tick_w)
    );

    // a value of zero expires after the first step
    assign expire_w = (state_r == WRF_COUNT) && step_tick_w && (count_r <= 5'h01);

    always_ff @(posedge clock_i) begin
        if (!rst_b_i || !watchdog_enable_r) begin
            state_r <= WRF_IDLE;
        end else begin
            unique case (state_r)
                WRF_IDLE: state_r <= WRF_ARMED;
                WRF_ARMED: if (freq_change_i) state_r <= WRF_COUNT;
                WRF_COUNT: if (expire_w) state_r <= WRF_LOCKED;
                WRF_LOCKED: state_r <= WRF_LOCKED;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            count_r <= `WRF_RST_TMR_VAL;
        end else if (state_r != WRF_COUNT) begin
            count_r <= timeout_value_r;
        end else if (step_tick_w && !expire_w) begin
            count_r <= count_r - 5'h01;
        end
    end

    // set wins over a clearing write in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            timeout_flag_r <= 1'b0;
        end else if (expire_w) begin
            timeout_flag_r <= 1'b1;
        end else if (wr_ctl_w && reg_wdata_i[`WRF_WD_FLAG_BIT]) begin
            timeout_flag_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // reset pulse and recovery outputs
    // ----------------------------------------
    logic [3:0] rst_cnt_r;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rst_cnt_r <= 4'h0;
            sys_reset_o <= 1'b0;
            recovery_load_o <= 1'b0;
        end else begin
            recovery_load_o <= expire_w;
            if (expire_w && watchdog_reset_enable_r) begin
                rst_cnt_r <= RST_CYC - 4'h1;
                sys_reset_o <= 1'b1;
            end else if (rst_cnt_r != 4'h0) begin
                rst_cnt_r <= rst_cnt_r - 4'h1;
            end else begin
                sys_reset_o <= 1'b0;
            end
        end
    end

    assign recovery_active_o = (state_r == WRF_LOCKED);
    // frequency-change writes die here while locked
    assign freq_wr_allow_o = freq_wr_req_i && !recovery_active_o;
    assign recovery_source_select_o = recovery_sel_m_r[`WRF_RM_SEL_BIT];
    assign recovery_n_divider_o = recovery_n_r;
    assign recovery_m_divider_o = recovery_sel_m_r[`WRF_RM_M_MSB:0];
    assign recovery_strap_o = strap_latched_r;

    // ----------------------------------------
    // ratio and skew
    // ----------------------------------------
    function automatic wrf_ps_t skew3(input logic [2:0] code);
        unique case (code)
            3'h0: skew3 = `WRF_PS_0;
            3'h1: skew3 = -`WRF_PS_P150;
            3'h2: skew3 = -`WRF_PS_P300;
            3'h3: skew3 = -`WRF_PS_P450;
            3'h4: skew3 = `WRF_PS_P150;
            3'h5: skew3 = `WRF_PS_P300;
            3'h6: skew3 = `WRF_PS_P450;
            3'h7: skew3 = `WRF_PS_P600;
        endcase
    endfunction

    function automatic wrf_ps_t skew2(input logic [1:0] code);
        unique case (code)
            2'h0: skew2 = `WRF_PS_0;
            2'h1: skew2 = -`WRF_PS_P150;
            2'h2: skew2 = `WRF_PS_P150;
            2'h3: skew2 = `WRF_PS_P300;
        endcase
    endfunction

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            ratio_sel_o <= 5'h00;
            cpu_cs_skew_ps_o <= `WRF_PS_0;
            cpu_skew_ps_o <= `WRF_PS_0;
            agp_clock_skew_ps_o <= `WRF_PS_0;
        end else begin
            ratio_sel_o <= ratio_override_i ? sw_ratio_sel_i : strap_latched_r;
            cpu_cs_skew_ps_o <= skew3(skew_r[`WRF_SK_CS_MSB:`WRF_SK_CS_LSB]);
            cpu_skew_ps_o <= skew3(skew_r[`WRF_SK_CPU_MSB:`WRF_SK_CPU_LSB]);
            agp_clock_skew_ps_o <= skew2(skew_r[`WRF_SK_AGP_MSB:`WRF_SK_AGP_LSB]);
        end
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            unique case (reg_addr_i)
                `WRF_OFF_TIMER: reg_rdata_o <= {2'h0, timeout_value_r, timeout_step_select_r};
                `WRF_OFF_WDCTL: reg_rdata_o <= {1'b0, wd_keep_r, timeout_flag_r,
                                                watchdog_enable_r, 1'b0};
                `WRF_OFF_SKEW: reg_rdata_o <= skew_r;
                `WRF_OFF_RECN: reg_rdata_o <= recovery_n_r;
                `WRF_OFF_RECM: reg_rdata_o <= recovery_sel_m_r;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_flag_on_expire: assert property (
        expire_w |=> timeout_flag_r)
        else $error("flag not set on time-out");
    a_flag_clear_one: assert property (
        wr_ctl_w && reg_wdata_i[`WRF_WD_FLAG_BIT] && !expire_w |=> !timeout_flag_r)
        else $error("flag not cleared by write of one");
    a_flag_keep_zero: assert property (
        timeout_flag_r && !(wr_ctl_w && reg_wdata_i[`WRF_WD_FLAG_BIT]) |=> timeout_flag_r)
        else $error("flag lost without clear");
    a_reload_idle: assert property (
        !watchdog_enable_r ##1 !watchdog_enable_r |=> count_r == $past(timeout_value_r))
        else $error("counter not reloaded while disabled");
    a_wait_change: assert property (
        state_r == WRF_ARMED && !freq_change_i |=> state_r != WRF_COUNT)
        else $error("count began without frequency change");
    a_expire_lock: assert property (
        expire_w && watchdog_enable_r |=> recovery_active_o && recovery_load_o)
        else $error("no lock after time-out");
    a_lock_blocks: assert property (recovery_active_o |-> !freq_wr_allow_o)
        else $error("frequency write passed while locked");
    a_unlock_clear: assert property (
        wr_ctl_w && !reg_wdata_i[`WRF_WATCHDOG_ENABLE_BIT] |=> ##1 !recovery_active_o)
        else $error("lock held after enable cleared");
    a_count_steps: assert property (
        state_r == WRF_COUNT && !step_tick_w |=> count_r == $past(count_r))
        else $error("count moved without a step");
    a_reset_pulse: assert property (
        expire_w && watchdog_reset_enable_r |=> sys_reset_o [*8])
        else $error("reset pulse too short");
    a_reset_gated: assert property (
        expire_w && !watchdog_reset_enable_r && !sys_reset_o |=> !sys_reset_o)
        else $error("reset pulse while disabled");
    a_ratio_mux: assert property (ratio_override_i |=> ratio_sel_o == $past(sw_ratio_sel_i))
        else $error("override ratio not followed");
    a_skew_top: assert property (skew_r[7:5] == 3'h7 |=> cpu_cs_skew_ps_o == 11'sd600)
        else $error("chipset skew code wrong");
    a_agp_neg: assert property (skew_r[1:0] == 2'h1 |=> agp_clock_skew_ps_o == -11'sd150)
        else $error("agp_clock_skew code wrong");

    c_timeout: cover property (expire_w && watchdog_reset_enable_r);
    c_unlock: cover property (recovery_active_o ##1 !watchdog_enable_r);
    c_blocked: cover property (recovery_active_o && freq_wr_req_i);
    c_strap: cover property (!latched_r ##1 latched_r);
endmodule

// *** verification/wrf_watchdog_top_tb.sv ***
// self-checking bench for the watchdog recovery frequency control
// assumes wrf_regs.svh on the include path and wrf_pkg compiled first
`timescale 1ns/10ps
`include "wrf_regs.svh"
module wrf_watchdog_top_tb import wrf_pkg::*;;
    // ----------------------------------------
    // short step counts keep the run brief
    // ----------------------------------------
    localparam int SHORT = 20;
    localparam int LONG = 50;

    logic clock_i = 1'b0;
    logic rst_b_i;
    logic reg_wr_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    logic freq_change_i;
    logic freq_wr_req_i;
    logic freq_wr_allow_o;
    logic [4:0] strap_frequency_select_i;
    logic ratio_override_i;
    logic [4:0] sw_ratio_sel_i;
    logic [4:0] ratio_sel_o;
    logic sys_reset_o;
    logic recovery_load_o;
    logic recovery_active_o;
    logic recovery_source_select_o;
    logic [7:0] recovery_n_divider_o;
    logic [6:0] recovery_m_divider_o;
    logic [4:0] recovery_strap_o;
    wrf_ps_t cpu_cs_skew_ps_o;
    wrf_ps_t cpu_skew_ps_o;
    wrf_ps_t agp_clock_skew_ps_o;
    int fails = 0;
    int n_compared = 0;
    int n_rst = 0;
    int n_load = 0;
    logic [7:0] rv;

    wrf_watchdog_top #(.STEP_SHORT_CYC(SHORT), .STEP_LONG_CYC(LONG)) u_wrf_watchdog_top (
        .clock_i(clock_i), .rst_b_i(rst_b_i),
        .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .freq_change_i(freq_change_i), .freq_wr_req_i(freq_wr_req_i),
        .freq_wr_allow_o(freq_wr_allow_o),
        .strap_frequency_select_i(strap_frequency_select_i),
        .ratio_override_i(ratio_override_i), .sw_ratio_sel_i(sw_ratio_sel_i),
        .ratio_sel_o(ratio_sel_o),
        .sys_reset_o(sys_reset_o), .recovery_load_o(recovery_load_o),
        .recovery_active_o(recovery_active_o),
        .recovery_source_select_o(recovery_source_select_o),
        .recovery_n_divider_o(recovery_n_divider_o),
        .recovery_m_divider_o(recovery_m_divider_o), .recovery_strap_o(recovery_strap_o),
        .cpu_cs_skew_ps_o(cpu_cs_skew_ps_o), .cpu_skew_ps_o(cpu_skew_ps_o),
        .agp_clock_skew_ps_o(agp_clock_skew_ps_o)
    );

    always #50 clock_i = ~clock_i;

    // pulse widths are counted here so a stuck pulse shows as a wrong count
    always @(posedge clock_i) begin
        if (sys_reset_o === 1'b1) begin
            n_rst++;
        end
        if (recovery_load_o === 1'b1) begin
            n_load++;
        end
    end

    // ----------------------------------------
    // compare, access and closing tasks
    // ----------------------------------------
    task automatic chk_v(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_b(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data is registered, so two edges pass before sampling
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        repeat (2) @(posedge clock_i);
        #1 d = reg_rdata_o;
    endtask

    task automatic pulse_change();
        @(posedge clock_i);
        freq_change_i <= 1'b1;
        @(posedge clock_i);
        freq_change_i <= 1'b0;
    endtask

    // arm, check no count before a frequency change, then time the expiry
    task automatic run_wd(input logic [7:0] tmr, input logic [7:0] ctl, input int exp);
        int n;
        wr(`WRF_OFF_TIMER, tmr);
        wr(`WRF_OFF_WDCTL, ctl);
        repeat (100) @(posedge clock_i);
        #1 chk_b("idle before change", 1'b0, recovery_active_o);
        n_rst = 0;
        n_load = 0;
        pulse_change();
        n = 1;
        while (recovery_active_o !== 1'b1 && n < 2000) begin
            @(posedge clock_i);
            n++;
        end
        chk_b("expiry span", 1'b1, n >= exp - 2 && n <= exp + 6);
        repeat (20) @(posedge clock_i);
        #1 chk_b("locked", 1'b1, recovery_active_o);
        chk_v("load pulses", 11'h001, 11'(n_load));
        rd(`WRF_OFF_WDCTL, rv);
        chk_v("flag set", 11'(ctl | 8'h04), 11'(rv));
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 100);
        fails++;
        complete_run();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int cs_ps[8];
        int agp_ps[4];
        logic [7:0] rst_addr[6];
        logic [7:0] rst_val[6];
        cs_ps = '{0, -150, -300, -450, 150, 300, 450, 600};
        agp_ps = '{0, -150, 150, 300};
        rst_addr = '{8'h04, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h20};
        rst_val = '{8'h3E, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        rst_b_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        freq_change_i = 1'b0;
        freq_wr_req_i = 1'b0;
        strap_frequency_select_i = 5'h13;
        ratio_override_i = 1'b0;
        sw_ratio_sel_i = 5'h07;
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        // reset values, with an unmapped offset reading zero
        for (int i = 0; i < 6; i++) begin
            rd(rst_addr[i], rv);
            chk_v("reset byte", 11'(rst_val[i]), 11'(rv));
        end
        chk_b("source reset", 1'b0, recovery_source_select_o);
        // every skew code on all three fields
        for (int c = 0; c < 8; c++) begin
            wr(`WRF_OFF_SKEW, {3'(c), 3'(c), 2'(c)});
            rd(`WRF_OFF_SKEW, rv);
            chk_v("skew byte", 11'({3'(c), 3'(c), 2'(c)}), 11'(rv));
            chk_v("cs skew", 11'(cs_ps[c]), cpu_cs_skew_ps_o);
            chk_v("cpu skew", 11'(cs_ps[c]), cpu_skew_ps_o);
            chk_v("agp_clock_skew", 11'(agp_ps[c % 4]), agp_clock_skew_ps_o);
        end
        // recovery source and dividers
        chk_v("strap latch", 11'h013, 11'(recovery_strap_o));
        wr(`WRF_OFF_RECN, 8'hA5);
        wr(`WRF_OFF_RECM, 8'hDA);
        rd(`WRF_OFF_RECM, rv);
        chk_v("m byte", 11'h0DA, 11'(rv));
        chk_b("source sel", 1'b1, recovery_source_select_o);
        chk_v("n div", 11'h0A5, 11'(recovery_n_divider_o));
        chk_v("m div", 11'h05A, 11'(recovery_m_divider_o));
        // ratio source follows the override
        chk_v("ratio strap", 11'h013, 11'(ratio_sel_o));
        @(posedge clock_i);
        ratio_override_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1 chk_v("ratio sw", 11'h007, 11'(ratio_sel_o));
        @(posedge clock_i);
        ratio_override_i <= 1'b0;
        // disabled watchdog never expires, even after a change
        wr(`WRF_OFF_TIMER, 8'h04);
        wr(`WRF_OFF_WDCTL, 8'h10);
        pulse_change();
        repeat (200) @(posedge clock_i);
        #1 chk_b("disabled", 1'b0, recovery_active_o);
        rd(`WRF_OFF_WDCTL, rv);
        chk_v("no flag", 11'h010, 11'(rv));
        // value 2, short steps, reset pulse enabled
        run_wd(8'h04, 8'h12, 2 * SHORT);
        chk_v("reset cycles", 11'h00A, 11'(n_rst));
        @(posedge clock_i);
        freq_wr_req_i <= 1'b1;
        @(posedge clock_i);
        #1 chk_b("write refused", 1'b0, freq_wr_allow_o);
        wr(`WRF_OFF_WDCTL, 8'h12);
        rd(`WRF_OFF_WDCTL, rv);
        chk_v("flag kept", 11'h016, 11'(rv));
        wr(`WRF_OFF_WDCTL, 8'h16);
        rd(`WRF_OFF_WDCTL, rv);
        chk_v("flag cleared", 11'h012, 11'(rv));
        chk_b("still locked", 1'b1, recovery_active_o);
        wr(`WRF_OFF_WDCTL, 8'h10);
        repeat (3) @(posedge clock_i);
        #1 chk_b("unlocked", 1'b0, recovery_active_o);
        chk_b("write allowed", 1'b1, freq_wr_allow_o);
        @(posedge clock_i);
        freq_wr_req_i <= 1'b0;
        // value 3 short steps, then value 1 long steps, reset pulse off
        run_wd(8'h06, 8'h02, 3 * SHORT);
        chk_v("no reset", 11'h000, 11'(n_rst));
        wr(`WRF_OFF_WDCTL, 8'h04);
        run_wd(8'h03, 8'h02, LONG);
        chk_v("no reset long", 11'h000, 11'(n_rst));
        wr(`WRF_OFF_WDCTL, 8'h04);
        repeat (3) @(posedge clock_i);
        #1 chk_b("final unlock", 1'b0, recovery_active_o);
        complete_run();
    end
endmodule
